//--- hdl/atx_fifo.sv
`timescale 1ns/1ps
module atx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_reg != FULL;
	assign out_valid = cnt_reg != '0;
	assign out_data = mem[rd_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : atx_fifo

//--- hdl/atx_regs_top.sv
`timescale 1ns/1ps
//
// Notes on behaviour
// - Adjust word resets C4F7h, command byte C4h
// - Bits 7..6 pick adjust mode
// - Mode 10 clears offset while valid-data low
// - Mode 11 keeps offset regardless of valid-data
// - Valid-data rising triggers one automatic sample in modes 10 and 11
// - Bits 5..4 clamp offset to limit
// - Tuning step 2.5, 5, 7.5 kHz per band
// - Strobe bit 3 starts one manual sample
// - Fine bit doubles measurement time
// - Bit 1 applies offset to synthesizer
// - Bit 0 enables offset calculation
// - Transmit config resets 9800h, command bits 15..9
// - Polarity bit 8 inverts bit-to-frequency mapping
// - Deviation is 15 kHz times code plus one
// - Power code attenuates 3 dB per step
// - Transmit byte resets AAh, word B8AAh
// - Byte register used only when enabled
// - Transmitter enable sends held byte at once
// - Serial data out high when byte loadable
// - Leading zero means status read, no write
// - Streamed bytes after transmit command load directly
module atx_regs_top #(
	parameter int FIFO_DEPTH = 4,
	parameter int MEAS_CYC = atx_pkg::MEAS_CYC,
	parameter int TX_BIT_CYC = atx_pkg::TX_BIT_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Serial command port
	input wire logic SCK,
	input wire logic SDI,
	input wire logic CS_N,
	output logic SDO,
	// Receiver side
	input wire logic VALID_DATA_INDICATION,
	input wire logic [7:0] MEAS_OFFSET,
	input wire logic [1:0] BAND,
	output logic [7:0] FREQ_OFFSET,
	output logic MEAS_BUSY,
	output logic [12:0] STEP_HZ,
	// Transmitter side
	input wire logic TX_ENABLE,
	input wire logic TX_DATA_REG_ENABLE,
	input wire logic DATA_PIN,
	output logic [7:0] DEV_KHZ,
	output logic [4:0] ATTEN_DB,
	output logic TX_MOD,
	output logic TX_ACTIVE
);
	localparam int MW = $clog2(2 * MEAS_CYC + 1);
	localparam int DW = $clog2(TX_BIT_CYC + 1);

	function automatic logic signed [7:0] clamp_offset(input logic signed [7:0] v, input logic [1:0] lim);
		logic signed [7:0] hi;
		logic signed [7:0] lo;
		hi = (lim == 2'h1) ? atx_pkg::LIM1_HI : (lim == 2'h2) ? atx_pkg::LIM2_HI : atx_pkg::LIM3_HI;
		lo = (lim == 2'h1) ? atx_pkg::LIM1_LO : (lim == 2'h2) ? atx_pkg::LIM2_LO : atx_pkg::LIM3_LO;
		if (lim == 2'h0)
			return v;
		else if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		else
			return v;
	endfunction : clamp_offset

	// Serial front end
	logic sck_rise;
	logic sdi_bit;
	logic cs_low;
	logic cs_rise;
	logic cs_fall;

	atx_spi_sync u_sync (
		.clk(CLK),
		.rst_n(RSTN),
		.sck(SCK),
		.sdi(SDI),
		.cs_n(CS_N),
		.sck_rise(sck_rise),
		.sdi_bit(sdi_bit),
		.cs_low(cs_low),
		.cs_rise(cs_rise),
		.cs_fall(cs_fall)
	);

	logic [15:0] shift_reg;
	logic [4:0] bit_cnt_reg;
	logic stream_reg;
	atx_pkg::atx_fa_t fa_reg;
	atx_pkg::atx_tc_t tc_reg;

	wire word_edge = sck_rise && cs_low;
	wire [15:0] shift_next = {shift_reg[14:0], sdi_bit};
	wire [4:0] cnt_next = (stream_reg && bit_cnt_reg == atx_pkg::STREAM_LAST) ? atx_pkg::WORD_BITS :
		(bit_cnt_reg == atx_pkg::CNT_MAX) ? atx_pkg::CNT_MAX : bit_cnt_reg + 5'h01;
	// Streamed bytes reuse the wrapped count, so the new byte is always the low half
	wire byte_push = word_edge && cnt_next == atx_pkg::WORD_BITS &&
		(stream_reg || shift_next[15:8] == atx_pkg::TB_CMD);
	wire commit = cs_rise && bit_cnt_reg == atx_pkg::WORD_BITS && !stream_reg && shift_reg[15];
	wire fa_wr = commit && shift_reg[15:8] == atx_pkg::FA_CMD;
	wire tc_wr = commit && shift_reg[15:9] == atx_pkg::TC_CMD;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			shift_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			stream_reg <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_reg <= 5'h00;
			stream_reg <= 1'b0;
		end else if (word_edge) begin
			shift_reg <= shift_next;
			bit_cnt_reg <= cnt_next;
			if (byte_push)
				stream_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fa_reg <= atx_pkg::FA_RESET_FIELDS;
			tc_reg <= atx_pkg::TC_RESET_FIELDS;
		end else begin
			// Words with a leading zero are status reads and never commit
			if (fa_wr)
				fa_reg <= shift_reg[7:0];
			if (tc_wr)
				tc_reg <= shift_reg[8:0];
		end
	end

	// Valid-data and data pin synchronisers
	logic [1:0] vdi_s_reg;
	logic vdi_prev_reg;
	logic [1:0] pin_s_reg;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			vdi_s_reg <= 2'h0;
			vdi_prev_reg <= 1'b0;
			pin_s_reg <= 2'h0;
		end else begin
			vdi_s_reg <= {vdi_s_reg[0], VALID_DATA_INDICATION};
			vdi_prev_reg <= vdi_s_reg[1];
			pin_s_reg <= {pin_s_reg[0], DATA_PIN};
		end
	end

	wire valid_data_indication = vdi_s_reg[1];
	wire vdi_rise = valid_data_indication && !vdi_prev_reg;

	// Frequency adjust unit
	atx_pkg::atx_state_t meas_state_reg;
	logic [MW-1:0] meas_cnt_reg;
	logic [MW-1:0] meas_len_reg;
	logic strobe_prev_reg;
	logic once_done_reg;
	logic signed [7:0] offset_reg;

	wire atx_pkg::atx_mode_t mode = atx_pkg::atx_mode_t'(fa_reg.adjust_mode);
	wire strobe_rise = fa_reg.sample_strobe && !strobe_prev_reg;
	wire auto_trig = ((mode == atx_pkg::ATX_MODE_RX_ONLY || mode == atx_pkg::ATX_MODE_KEEP) && vdi_rise) ||
		(mode == atx_pkg::ATX_MODE_ONCE && !once_done_reg);
	wire meas_start = meas_state_reg == atx_pkg::ATX_IDLE && (strobe_rise || auto_trig);
	wire [MW-1:0] meas_len = fa_reg.fine_accuracy ? MW'(2 * MEAS_CYC) : MW'(MEAS_CYC);
	wire meas_done = meas_state_reg == atx_pkg::ATX_BUSY && meas_cnt_reg == meas_len_reg - 1'b1;
	wire clear_now = mode == atx_pkg::ATX_MODE_RX_ONLY && !valid_data_indication;
	wire meas_store = meas_done && fa_reg.offset_calc_enable;
	wire signed [7:0] clamped = clamp_offset(MEAS_OFFSET, fa_reg.offset_limit);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			strobe_prev_reg <= 1'b0;
			once_done_reg <= 1'b0;
		end else begin
			strobe_prev_reg <= fa_reg.sample_strobe;
			if (meas_start && mode == atx_pkg::ATX_MODE_ONCE)
				once_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			meas_state_reg <= atx_pkg::ATX_IDLE;
			meas_cnt_reg <= '0;
			meas_len_reg <= '0;
		end else begin
			case (meas_state_reg)
				atx_pkg::ATX_IDLE: begin
					meas_cnt_reg <= '0;
					meas_len_reg <= meas_len;
					if (meas_start)
						meas_state_reg <= atx_pkg::ATX_BUSY;
				end
				atx_pkg::ATX_BUSY: begin
					meas_cnt_reg <= meas_cnt_reg + 1'b1;
					if (meas_done)
						meas_state_reg <= atx_pkg::ATX_IDLE;
				end
				default: meas_state_reg <= atx_pkg::ATX_IDLE;
			endcase
		end
	end

	// Clearing wins in mode 10 since poor reception makes the sample worthless
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			offset_reg <= 8'sh00;
		else if (clear_now)
			offset_reg <= 8'sh00;
		else if (meas_store)
			offset_reg <= clamped;
	end

	assign MEAS_BUSY = meas_state_reg == atx_pkg::ATX_BUSY;

	// Transmit path
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [7:0] hold_reg;
	logic hold_valid_reg;
	atx_pkg::atx_state_t tx_state_reg;
	logic [7:0] tx_sh_reg;
	logic [2:0] tx_bits_reg;
	logic [DW-1:0] div_reg;

	atx_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RSTN),
		.in_valid(byte_push),
		.in_ready(fifo_in_ready),
		.in_data(shift_next[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(!hold_valid_reg),
		.out_data(fifo_out_data)
	);

	// Ready to take a byte whenever the buffer has room
	assign SDO = fifo_in_ready;

	wire bit_tick = div_reg == DW'(TX_BIT_CYC - 1);
	wire last_bit = bit_tick && tx_bits_reg == 3'h7;
	wire can_start = TX_ENABLE && TX_DATA_REG_ENABLE && hold_valid_reg;
	wire tx_idle = tx_state_reg == atx_pkg::ATX_IDLE;
	wire load = can_start && (tx_idle || last_bit);
	wire pop = fifo_out_valid && !hold_valid_reg;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hold_reg <= atx_pkg::TB_RESET_BYTE;
			hold_valid_reg <= 1'b1;
		end else if (pop) begin
			hold_reg <= fifo_out_data;
			hold_valid_reg <= 1'b1;
		end else if (load) begin
			hold_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_state_reg <= atx_pkg::ATX_IDLE;
			tx_sh_reg <= 8'h00;
			tx_bits_reg <= 3'h0;
			div_reg <= '0;
		end else begin
			case (tx_state_reg)
				atx_pkg::ATX_IDLE: begin
					div_reg <= '0;
					if (load)
						tx_state_reg <= atx_pkg::ATX_BUSY;
				end
				atx_pkg::ATX_BUSY: begin
					div_reg <= (bit_tick || load) ? '0 : div_reg + 1'b1;
					if (!TX_ENABLE || (last_bit && !load))
						tx_state_reg <= atx_pkg::ATX_IDLE;
				end
				default: tx_state_reg <= atx_pkg::ATX_IDLE;
			endcase
			if (load) begin
				tx_sh_reg <= hold_reg;
				tx_bits_reg <= 3'h0;
			end else if (bit_tick) begin
				tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
				tx_bits_reg <= tx_bits_reg + 3'h1;
			end
		end
	end

	assign TX_ACTIVE = !tx_idle;

	// Without the byte register the pin modulates directly
	wire tx_src = TX_DATA_REG_ENABLE ? (tx_sh_reg[7] && !tx_idle) : pin_s_reg[1];
	wire [7:0] dev_next = (8'({4'h0, tc_reg.deviation_code}) + 8'h01) * atx_pkg::DEV_STEP_KHZ;
	wire [4:0] atten_next = 5'({2'h0, tc_reg.power_code}) * atx_pkg::PWR_STEP_DB;
	wire [12:0] step_next = (BAND == atx_pkg::BAND_433) ? atx_pkg::STEP_433_HZ :
		(BAND == atx_pkg::BAND_868) ? atx_pkg::STEP_868_HZ :
		(BAND == atx_pkg::BAND_916) ? atx_pkg::STEP_916_HZ : 13'h0000;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			TX_MOD <= 1'b0;
			DEV_KHZ <= 8'h00;
			ATTEN_DB <= 5'h00;
			STEP_HZ <= 13'h0000;
			FREQ_OFFSET <= 8'h00;
		end else begin
			TX_MOD <= tx_src ^ tc_reg.deviation_polarity;
			DEV_KHZ <= dev_next;
			ATTEN_DB <= atten_next;
			STEP_HZ <= step_next;
			FREQ_OFFSET <= fa_reg.apply_offset_enable ? offset_reg : 8'h00;
		end
	end

	// Checks
	localparam int A_NORM = MEAS_CYC;
	localparam int A_FINE = 2 * MEAS_CYC;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	a_fa_commit:
	assert property (fa_wr |=> fa_reg == $past(shift_reg[7:0])) else $error("adjust word not committed");

	a_tc_commit:
	assert property (tc_wr |=> tc_reg == $past(shift_reg[8:0])) else $error("config word not committed");

	a_status_no_write:
	assert property (cs_rise && !shift_reg[15] |=> $stable(fa_reg) && $stable(tc_reg))
		else $error("status read changed a register");

	a_rx_only_clear:
	assert property (mode == atx_pkg::ATX_MODE_RX_ONLY && !valid_data_indication |=> offset_reg == 8'sh00)
		else $error("offset not cleared without valid data");

	a_keep_offset:
	assert property (mode == atx_pkg::ATX_MODE_KEEP && !meas_store |=> $stable(offset_reg))
		else $error("offset lost in keep mode");

	a_meas_normal_len:
	assert property (meas_start && !fa_reg.fine_accuracy |-> ##A_NORM meas_done)
		else $error("normal measurement length wrong");

	a_meas_fine_len:
	assert property (meas_start && fa_reg.fine_accuracy |-> ##A_FINE meas_done)
		else $error("fine measurement length wrong");

	a_strobe_single:
	assert property (meas_start && !auto_trig |-> strobe_rise ##1 !strobe_rise)
		else $error("held strobe relaunched");

	a_calc_gate:
	assert property (meas_done && !fa_reg.offset_calc_enable && !clear_now |=> $stable(offset_reg))
		else $error("offset stored while calculation off");

	a_limit_tight:
	assert property (meas_store && !clear_now && fa_reg.offset_limit == 2'h3 |=>
		offset_reg <= atx_pkg::LIM3_HI && offset_reg >= atx_pkg::LIM3_LO) else $error("offset exceeds limit");

	a_apply_gate:
	assert property (!fa_reg.apply_offset_enable |=> FREQ_OFFSET == 8'h00) else $error("offset applied while off");

	a_tx_start:
	assert property (tx_idle && can_start |=> TX_ACTIVE && tx_sh_reg == $past(hold_reg))
		else $error("transmit did not start");

	a_polarity:
	assert property (1'b1 |=> TX_MOD == ($past(tx_src) ^ $past(tc_reg.deviation_polarity)))
		else $error("modulation polarity wrong");

	a_sdo_full:
	assert property (byte_push && !SDO && !pop |=> !SDO) else $error("byte accepted while full");

	c_manual_sample: cover property (strobe_rise && meas_start ##[1:400] meas_store);
	c_stream_two: cover property (byte_push ##[1:400] byte_push && stream_reg);
	c_tx_back_to_back: cover property (last_bit && load);
endmodule : atx_regs_top

//--- hdl/atx_spi_sync.sv
`timescale 1ns/1ps
module atx_spi_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial pins
	input wire logic sck,
	input wire logic sdi,
	input wire logic cs_n,
	// Sampled events
	output logic sck_rise,
	output logic sdi_bit,
	output logic cs_low,
	output logic cs_rise,
	output logic cs_fall
);
	// Order: sck, sdi, cs_n; all three share the same latency
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic sck_prev_reg;
	logic cs_prev_reg;

	assign sck_rise = s2_reg[2] && !sck_prev_reg;
	assign sdi_bit = s2_reg[1];
	assign cs_low = !s2_reg[0];
	assign cs_rise = s2_reg[0] && !cs_prev_reg;
	assign cs_fall = !s2_reg[0] && cs_prev_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 3'h1;
			s2_reg <= 3'h1;
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			s1_reg <= {sck, sdi, cs_n};
			s2_reg <= s1_reg;
			sck_prev_reg <= s2_reg[2];
			cs_prev_reg <= s2_reg[0];
		end
	end
endmodule : atx_spi_sync

//--- pkg/atx_pkg.sv
package atx_pkg;
	// Command words and reset values
	localparam logic [15:0] FA_RESET = 16'hC4F7;
	localparam logic [7:0] FA_CMD = 8'hC4;
	localparam logic [15:0] TC_RESET = 16'h9800;
	localparam logic [6:0] TC_CMD = 7'h4C;
	localparam logic [15:0] TB_RESET = 16'hB8AA;
	localparam logic [7:0] TB_CMD = 8'hB8;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] STREAM_LAST = 5'h17;
	localparam logic [4:0] CNT_MAX = 5'h1F;

	typedef struct packed {
		logic [1:0] adjust_mode;
		logic [1:0] offset_limit;
		logic sample_strobe;
		logic fine_accuracy;
		logic apply_offset_enable;
		logic offset_calc_enable;
	} atx_fa_t;

	typedef struct packed {
		logic deviation_polarity;
		logic [3:0] deviation_code;
		logic spare;
		logic [2:0] power_code;
	} atx_tc_t;

	localparam atx_fa_t FA_RESET_FIELDS = atx_fa_t'(FA_RESET[7:0]);
	localparam atx_tc_t TC_RESET_FIELDS = atx_tc_t'(TC_RESET[8:0]);
	localparam logic [7:0] TB_RESET_BYTE = TB_RESET[7:0];

	typedef enum logic [1:0] {
		ATX_MODE_OFF = 2'h0,
		ATX_MODE_ONCE = 2'h1,
		ATX_MODE_RX_ONLY = 2'h2,
		ATX_MODE_KEEP = 2'h3
	} atx_mode_t;

	typedef enum logic [1:0] {
		ATX_IDLE = 2'b01,
		ATX_BUSY = 2'b10
	} atx_state_t;

	// Offset limits in tuning steps
	localparam logic signed [7:0] LIM1_HI = 8'sh0F;
	localparam logic signed [7:0] LIM1_LO = 8'shF0;
	localparam logic signed [7:0] LIM2_HI = 8'sh07;
	localparam logic signed [7:0] LIM2_LO = 8'shF8;
	localparam logic signed [7:0] LIM3_HI = 8'sh03;
	localparam logic signed [7:0] LIM3_LO = 8'shFC;

	// Tuning step per band, in Hz
	localparam logic [1:0] BAND_433 = 2'h1;
	localparam logic [1:0] BAND_868 = 2'h2;
	localparam logic [1:0] BAND_916 = 2'h3;
	localparam logic [12:0] STEP_433_HZ = 13'h09C4;
	localparam logic [12:0] STEP_868_HZ = 13'h1388;
	localparam logic [12:0] STEP_916_HZ = 13'h1D4C;
	localparam logic [7:0] DEV_STEP_KHZ = 8'h0F;
	localparam logic [4:0] PWR_STEP_DB = 5'h03;

	// Timing
	localparam int CLK_NS = 20;
	localparam int MEAS_NS = 2000;
	localparam int MEAS_CYC = (MEAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int TX_BIT_NS = 4000;
	localparam int TX_BIT_CYC = TX_BIT_NS / CLK_NS;
endpackage : atx_pkg

//--- tb/atx_host.sv
`timescale 1ns/1ps
module atx_host (
	// Clock
	input wire logic clk,
	// Serial port
	output logic sck,
	output logic sdi,
	output logic cs_n
);
	// Serial clock stands low between frames
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end

	task automatic half();
		repeat (4) @(negedge clk);
	endtask : half

	task automatic cs_low();
		@(negedge clk);
		cs_n = 1'b0;
		half();
	endtask : cs_low

	task automatic put_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sdi = b[i];
			half();
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
	endtask : put_byte

	// Deselected data line shows the inverse, never a stale bit
	task automatic cs_high();
		half();
		cs_n = 1'b1;
		sdi = ~sdi;
		half();
	endtask : cs_high

	task automatic write_word(input logic [15:0] w);
		cs_low();
		put_byte(w[15:8]);
		put_byte(w[7:0]);
		cs_high();
	endtask : write_word
endmodule : atx_host

//--- tb/atx_regs_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module atx_regs_top_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic valid_data_indication = 1'b0;
	logic [7:0] meas = 8'h00;
	logic [1:0] band = 2'h0;
	logic tx_en = 1'b0;
	logic reg_en = 1'b0;
	logic pin = 1'b0;
	wire sck, sdi, cs_n, sdo, busy, tx_mod, tx_act;
	wire [7:0] foff, dev;
	wire [12:0] step;
	wire [4:0] att;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int run = 0;
	int blen = 0;
	int npulse = 0;
	int n1, n2, p;
	logic [39:0] got;
	logic [7:0] lims [8] = '{8'h40, 8'h0F, 8'h07, 8'h03, 8'hC0, 8'hF0, 8'hF8, 8'hFC};
	logic [12:0] steps [4] = '{13'h0000, 13'h09C4, 13'h1388, 13'h1D4C};

	always #10 clk = ~clk;

	atx_host i_atx_host (.clk(clk), .sck(sck), .sdi(sdi), .cs_n(cs_n));

	// Short counts keep the run brief
	localparam int MEAS_LEN = 16;
	atx_regs_top #(.FIFO_DEPTH(4), .MEAS_CYC(MEAS_LEN), .TX_BIT_CYC(8)) i_atx_regs_top (
		.CLK(clk), .RSTN(rstn), .SCK(sck), .SDI(sdi), .CS_N(cs_n), .SDO(sdo),
		.VALID_DATA_INDICATION(valid_data_indication), .MEAS_OFFSET(meas), .BAND(band), .FREQ_OFFSET(foff),
		.MEAS_BUSY(busy), .STEP_HZ(step), .TX_ENABLE(tx_en), .TX_DATA_REG_ENABLE(reg_en),
		.DATA_PIN(pin), .DEV_KHZ(dev), .ATTEN_DB(att), .TX_MOD(tx_mod), .TX_ACTIVE(tx_act)
	);

	// Length of the last measurement pulse and count of pulses
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (busy === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			blen <= run;
			npulse <= npulse + 1;
			run <= 0;
		end
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask : end_test

	function automatic logic [15:0] fa(input logic [1:0] m, l, input logic s, f, a, c);
		return {atx_pkg::FA_CMD, m, l, s, f, a, c};
	endfunction : fa

	function automatic logic [15:0] tc(input logic pl, input logic [3:0] d, input logic [2:0] pw);
		return {atx_pkg::TC_CMD, pl, d, 1'b0, pw};
	endfunction : tc

	task automatic wr(input logic [15:0] w);
		i_atx_host.write_word(w);
		repeat (4) @(negedge clk);
	endtask : wr

	task automatic wait_busy();
		int w;
		w = 0;
		repeat (8) @(negedge clk);
		while (busy === 1'b1 && w < 100) begin
			@(negedge clk);
			w++;
		end
		repeat (4) @(negedge clk);
	endtask : wait_busy

	task automatic stream(input int nb, input logic [39:0] d);
		i_atx_host.cs_low();
		i_atx_host.put_byte(atx_pkg::TB_CMD);
		for (int i = 0; i < nb; i++) begin
			i_atx_host.put_byte(d[39-8*i -: 8]);
		end
		i_atx_host.cs_high();
		repeat (4) @(negedge clk);
	endtask : stream

	// Samples each bit in the middle of its period
	task automatic capture(input int nb);
		int w;
		w = 0;
		got = '0;
		while (tx_act !== 1'b1 && w < 50) begin
			@(negedge clk);
			w++;
		end
		repeat (4) @(negedge clk);
		for (int i = 0; i < 8 * nb; i++) begin
			got = {got[38:0], tx_mod};
			repeat (8) @(negedge clk);
		end
	endtask : capture

	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		`CHK("sdo", 1'b1, sdo)
		`CHK("dev", 8'h0F, dev)
		`CHK("atten", 5'h00, att)
		`CHK("txact", 1'b0, tx_act)
		for (int b = 0; b < 4; b++) begin
			band = b[1:0];
			repeat (4) @(negedge clk);
			`CHK("step", steps[b], step)
		end
		end_test("reset");
		meas = 8'h7F;
		valid_data_indication = 1'b1;
		wait_busy();
		n1 = blen;
		`CHK("offset", 8'h03, foff)
		valid_data_indication = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("offset", 8'h03, foff)
		end_test("auto");
		for (int s = 0; s < 2; s++) begin
			meas = s ? 8'hC0 : 8'h40;
			for (int l = 0; l < 4; l++) begin
				wr(fa(2'h0, l[1:0], 1'b0, 1'b0, 1'b1, 1'b1));
				wr(fa(2'h0, l[1:0], 1'b1, 1'b0, 1'b1, 1'b1));
				wait_busy();
				if (s == 0 && l == 0) n2 = blen;
				`CHK("offset", lims[s*4+l], foff)
			end
		end
		`CHK("normal", MEAS_LEN, n2)
		`CHK("fine", 2 * MEAS_LEN, n1)
		p = npulse;
		wr(fa(2'h0, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1));
		wait_busy();
		`CHK("pulses", p, npulse)
		wr(fa(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1));
		`CHK("offset", 8'h00, foff)
		meas = 8'h02;
		wr(fa(2'h0, 2'h3, 1'b1, 1'b0, 1'b1, 1'b0));
		wait_busy();
		`CHK("offset", 8'hFC, foff)
		end_test("manual");
		meas = 8'h05;
		wr(fa(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
		valid_data_indication = 1'b1;
		wait_busy();
		`CHK("offset", 8'h05, foff)
		valid_data_indication = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("offset", 8'h00, foff)
		meas = 8'h06;
		wr(fa(2'h1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
		wait_busy();
		`CHK("offset", 8'h06, foff)
		end_test("modes");
		for (int d = 0; d < 16; d++) begin
			wr(tc(1'b0, d[3:0], d[2:0]));
			`CHK("dev", 8'(15 * (d + 1)), dev)
			`CHK("atten", 5'(3 * (d % 8)), att)
		end
		wr(tc(1'b0, 4'h0, 3'h0));
		// Calculation off around the status read
		wr(fa(2'h1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		wr(16'h18F7);
		`CHK("dev", 8'h0F, dev)
		`CHK("atten", 5'h00, att)
		`CHK("offset", 8'h06, foff)
		end_test("txconfig");
		reg_en = 1'b1;
		// Fifth byte meets a full buffer and must be dropped
		stream(5, {8'h3C, 8'h81, 8'h5A, 8'hF0, 8'h0F});
		`CHK("sdo", 1'b0, sdo)
		tx_en = 1'b1;
		capture(5);
		`CHK("bits", {8'hAA, 8'h3C, 8'h81, 8'h5A, 8'hF0}, got)
		tx_en = 1'b0;
		`CHK("sdo", 1'b1, sdo)
		wr(tc(1'b1, 4'h0, 3'h0));
		stream(1, {8'h96, 32'h0});
		tx_en = 1'b1;
		capture(1);
		`CHK("bits", 8'h69, got[7:0])
		reg_en = 1'b0;
		for (int d = 0; d < 2; d++) begin
			pin = d[0];
			repeat (6) @(negedge clk);
			`CHK("txmod", ~d[0], tx_mod)
		end
		tx_en = 1'b0;
		end_test("transmit");
		finish_test();
	end
endmodule : atx_regs_top_bench
